// ==== include/tmr_defines.vh ====
// register offsets, field positions, reset values and timing for the timer
// assumes inclusion by bare name from the rtl files
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH
// ==========================================================================
// register byte offsets on the apb bus
`define TMR_OFS_CTRL_A     12'h000
`define TMR_OFS_CTRL_B     12'h004
`define TMR_OFS_CTRL_C     12'h008
`define TMR_OFS_CNT_L      12'h00C
`define TMR_OFS_CNT_H      12'h010
`define TMR_OFS_CMPA_L     12'h014
`define TMR_OFS_CMPA_H     12'h018
`define TMR_OFS_CMPB_L     12'h01C
`define TMR_OFS_CMPB_H     12'h020
`define TMR_OFS_CAP_L      12'h024
`define TMR_OFS_CAP_H      12'h028
`define TMR_OFS_IRQ_MASK   12'h02C
`define TMR_OFS_IRQ_FLAGS  12'h030
// ==========================================================================
// field positions
`define TMR_B_NOISE        7
`define TMR_B_EDGE         6
`define TMR_B_RSVD         5
`define TMR_C_FORCE_A      7
`define TMR_C_FORCE_B      6
`define TMR_I_CAP          5
`define TMR_I_CMPB         2
`define TMR_I_CMPA         1
`define TMR_I_OVF          0
`define TMR_A_MASK         8'hF3
`define TMR_B_MASK         8'hDF
`define TMR_I_MASK         8'h27
// ==========================================================================
// reset values
`define TMR_RST_BYTE       8'h00
`define TMR_RST_WORD       16'h0000
// ==========================================================================
// timing
`define TMR_FILTER_LEN     4
`define TMR_SYNC_LEN       3
`endif

// ==== rtl/tmr_capture_filter.v ====
// capture input synchroniser and optional four-sample noise filter
// assumes an asynchronous pin input and a single pclk domain
`timescale 1ns/100ps
`include "tmr_defines.vh"
module tmr_capture_filter (
  input  wire pclk,
  input  wire presetn,
  input  wire pin_in,
  input  wire filter_en,
  output reg  level_out
);
  reg [2:0] sync;
  reg [3:0] hist;
  wire      sync_ok;

  // third stage compared with second; first stage only feeds the second
  assign sync_ok = (sync[1] == sync[2]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync      <= 3'h0;
      hist      <= 4'h0;
      level_out <= 1'b0;
    end else begin
      sync <= {sync[1], sync[0], pin_in};
      hist <= {hist[2:0], sync[2]};
      if (filter_en) begin
        // four equal samples before the output moves
        if (hist == 4'hF)
          level_out <= 1'b1;
        else if (hist == 4'h0)
          level_out <= 1'b0;
      end else if (sync_ok) begin
        level_out <= sync[2];
      end
    end
  end
endmodule // tmr_capture_filter

// ==== rtl/tmr_ext_clock.v ====
// external clock pin synchroniser with edge detect
// assumes pin_in may be looped back from an output driver
`timescale 1ns/100ps
`include "tmr_defines.vh"
module tmr_ext_clock (
  input  wire pclk,
  input  wire presetn,
  input  wire pin_in,
  input  wire rising_sel,
  output wire tick
);
  reg [2:0] sync;
  reg       level;
  reg       level_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync    <= 3'h0;
      level   <= 1'b0;
      level_d <= 1'b0;
    end else begin
      sync    <= {sync[1], sync[0], pin_in};
      level_d <= level;
      if (sync[1] == sync[2])
        level <= sync[2];
    end
  end

  // counts pin edges of the direction rising_sel selects, even when the pin is an output
  assign tick = rising_sel ? (level & ~level_d)
                           : (~level & level_d);
endmodule // tmr_ext_clock

// ==== rtl/tmr_timer16.v ====
// 16-bit timer with two compares and one capture, apb register slave
// assumes apb master on pclk, async pins synchronised inside
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "tmr_defines.vh"
module tmr_timer16 #(
  parameter PRESC_W = 10
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        capture_input_pin,
  input  wire        comparator_out,
  input  wire        capture_src_comparator,
  input  wire        ext_clock_pin,
  input  wire        global_irq_en,
  input  wire        vector_ack_capture,
  input  wire        vector_ack_compare_a,
  input  wire        vector_ack_compare_b,
  input  wire        vector_ack_overflow,
  output reg         compare_a_output,
  output reg         compare_b_output,
  output wire        irq_capture,
  output wire        irq_compare_a,
  output wire        irq_compare_b,
  output wire        irq_overflow
);
  // ========================================================================
  // registers
  reg  [7:0]         timer_ctrl_a;
  reg  [7:0]         timer_ctrl_b;
  reg  [15:0]        counter_register;
  reg  [15:0]        compare_a_register;
  reg  [15:0]        compare_b_register;
  reg  [15:0]        capture_register;
  reg  [7:0]         timer_irq_mask;
  reg  [7:0]         timer_irq_flags;
  reg  [7:0]         temp_high;
  reg  [PRESC_W-1:0] prescaler;
  reg                count_down;
  reg                block_match;
  reg                match_a_d;
  reg                match_b_d;
  reg                capt_level_d;
  reg  [31:0]        rdata;

  wire [3:0]  waveform_mode;
  wire [2:0]  clock_select;
  wire [1:0]  mode_a;
  wire [1:0]  mode_b;
  wire        wr_en;
  wire        rd_en;
  wire        ext_tick;
  wire        capt_level;
  wire        capt_raw;
  wire        capt_event;
  wire        top_is_capture;
  wire        top_is_cmpa;
  wire        is_pwm;
  wire        is_phase;
  wire [15:0] top_value;
  wire        at_top;
  wire        at_bottom;
  wire        ovf_set;
  wire        match_a;
  wire        match_b;
  wire        force_a;
  wire        force_b;
  reg         timer_tick;
  reg  [15:0] next_counter;
  reg         next_down;

  // ========================================================================
  // mode decode
  assign waveform_mode = {timer_ctrl_b[4:3], timer_ctrl_a[1:0]};
  assign clock_select  = timer_ctrl_b[2:0];
  assign mode_a        = timer_ctrl_a[7:6];
  assign mode_b        = timer_ctrl_a[5:4];
  assign top_is_capture = (waveform_mode == 4'h8) ||
                          (waveform_mode == 4'hA) ||
                          (waveform_mode == 4'hC) ||
                          (waveform_mode == 4'hE);
  assign top_is_cmpa   = (waveform_mode == 4'h4) ||
                         (waveform_mode == 4'h9) ||
                         (waveform_mode == 4'hB) ||
                         (waveform_mode == 4'hF);
  assign is_pwm   = !((waveform_mode == 4'h0) || (waveform_mode == 4'h4) ||
                      (waveform_mode == 4'hC));
  assign is_phase = (waveform_mode[3:2] == 2'h0 && waveform_mode[1:0] != 2'h0)
                    || (waveform_mode[3:2] == 2'h2);

  function [15:0] fixed_top;
    input [1:0] bits;
    begin
      case (bits)
        2'h1:    fixed_top = 16'h00FF;
        2'h2:    fixed_top = 16'h01FF;
        2'h3:    fixed_top = 16'h03FF;
        default: fixed_top = 16'hFFFF;
      endcase
    end
  endfunction

  assign top_value = top_is_capture ? capture_register :
                     top_is_cmpa    ? compare_a_register :
                     fixed_top(waveform_mode[1:0]);
  assign at_top    = (counter_register == top_value);
  assign at_bottom = (counter_register == 16'h0000);

  // ========================================================================
  // clock select and prescaler
  tmr_ext_clock u_ext (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (ext_clock_pin),
    .rising_sel (clock_select[0]),
    .tick       (ext_tick)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prescaler <= {PRESC_W{1'b0}};
    else
      prescaler <= prescaler + 1'b1;
  end

  // a prescaled tick fires when the low bits wrap
  always @* begin
    case (clock_select)
      3'h0:    timer_tick = 1'b0;
      3'h1:    timer_tick = 1'b1;
      3'h2:    timer_tick = (prescaler[2:0] == 3'h7);
      3'h3:    timer_tick = (prescaler[5:0] == 6'h3F);
      3'h4:    timer_tick = (prescaler[7:0] == 8'hFF);
      3'h5:    timer_tick = (prescaler[9:0] == 10'h3FF);
      default: timer_tick = ext_tick;
    endcase
  end

  // ========================================================================
  // capture path
  assign capt_raw = capture_src_comparator ? comparator_out
                                           : capture_input_pin;
  tmr_capture_filter u_filt (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (capt_raw),
    .filter_en (timer_ctrl_b[`TMR_B_NOISE]),
    .level_out (capt_level)
  );
  assign capt_event = !top_is_capture &&
                      (timer_ctrl_b[`TMR_B_EDGE] ?
                       (capt_level & ~capt_level_d) :
                       (~capt_level & capt_level_d));

  // ========================================================================
  // counting and compare
  assign match_a = (counter_register == compare_a_register);
  assign match_b = (counter_register == compare_b_register);
  assign ovf_set = timer_tick && (is_pwm ? (is_phase ? at_bottom && count_down
                                                     : at_top)
                                         : (counter_register == 16'hFFFF));

  always @* begin
    next_counter = counter_register;
    next_down    = count_down;
    if (timer_tick) begin
      if (is_phase) begin
        if (count_down) begin
          if (at_bottom) begin
            next_down    = 1'b0;
            next_counter = counter_register + 16'h0001;
          end else begin
            next_counter = counter_register - 16'h0001;
          end
        end else if (at_top) begin
          next_down    = 1'b1;
          next_counter = counter_register - 16'h0001;
        end else begin
          next_counter = counter_register + 16'h0001;
        end
      end else if (at_top && (is_pwm || !(waveform_mode == 4'h0))) begin
        next_counter = 16'h0000;
      end else begin
        next_counter = counter_register + 16'h0001;
      end
    end
  end

  // ========================================================================
  // apb slave, zero wait states
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = rdata;
  assign force_a = wr_en && paddr == `TMR_OFS_CTRL_C && !is_pwm &&
                   pwdata[`TMR_C_FORCE_A];
  assign force_b = wr_en && paddr == `TMR_OFS_CTRL_C && !is_pwm &&
                   pwdata[`TMR_C_FORCE_B];

  function out_next;
    input       cur;
    input [1:0] com;
    begin
      case (com)
        2'h1:    out_next = ~cur;
        2'h2:    out_next = 1'b0;
        2'h3:    out_next = 1'b1;
        default: out_next = cur;
      endcase
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctrl_a       <= `TMR_RST_BYTE;
      timer_ctrl_b       <= `TMR_RST_BYTE;
      counter_register   <= `TMR_RST_WORD;
      compare_a_register <= `TMR_RST_WORD;
      compare_b_register <= `TMR_RST_WORD;
      capture_register   <= `TMR_RST_WORD;
      timer_irq_mask     <= `TMR_RST_BYTE;
      timer_irq_flags    <= `TMR_RST_BYTE;
      temp_high          <= `TMR_RST_BYTE;
      count_down         <= 1'b0;
      block_match        <= 1'b0;
      match_a_d          <= 1'b0;
      match_b_d          <= 1'b0;
      capt_level_d       <= 1'b0;
      compare_a_output   <= 1'b0;
      compare_b_output   <= 1'b0;
    end else begin
      capt_level_d     <= capt_level;
      counter_register <= next_counter;
      count_down       <= next_down;
      if (timer_tick) begin
        match_a_d   <= match_a && !block_match;
        match_b_d   <= match_b && !block_match;
        block_match <= 1'b0;
      end else begin
        match_a_d <= 1'b0;
        match_b_d <= 1'b0;
      end
      // compare outputs in non-pwm modes; forces change pins only
      if (!is_pwm && ((timer_tick && match_a && !block_match) || force_a))
        compare_a_output <= out_next(compare_a_output, mode_a);
      if (!is_pwm && ((timer_tick && match_b && !block_match) || force_b))
        compare_b_output <= out_next(compare_b_output, mode_b);
      if (capt_event)
        capture_register <= counter_register;
      // flags: clear by one-write or vector, set wins
      if (wr_en && paddr == `TMR_OFS_IRQ_FLAGS)
        timer_irq_flags <= timer_irq_flags & ~(pwdata[7:0] & `TMR_I_MASK)
                           & `TMR_I_MASK;
      else
        timer_irq_flags <= timer_irq_flags & `TMR_I_MASK;
      if (vector_ack_capture)
        timer_irq_flags[`TMR_I_CAP] <= 1'b0;
      if (vector_ack_compare_a)
        timer_irq_flags[`TMR_I_CMPA] <= 1'b0;
      if (vector_ack_compare_b)
        timer_irq_flags[`TMR_I_CMPB] <= 1'b0;
      if (vector_ack_overflow)
        timer_irq_flags[`TMR_I_OVF] <= 1'b0;
      if (capt_event || (top_is_capture && timer_tick && at_top))
        timer_irq_flags[`TMR_I_CAP] <= 1'b1;
      if (match_a_d)
        timer_irq_flags[`TMR_I_CMPA] <= 1'b1;
      if (match_b_d)
        timer_irq_flags[`TMR_I_CMPB] <= 1'b1;
      if (ovf_set)
        timer_irq_flags[`TMR_I_OVF] <= 1'b1;
      // register writes; high bytes go through the temp byte
      if (wr_en) begin
        case (paddr)
          `TMR_OFS_CTRL_A:
            timer_ctrl_a <= pwdata[7:0] & `TMR_A_MASK;
          `TMR_OFS_CTRL_B:
            timer_ctrl_b <= pwdata[7:0] & `TMR_B_MASK;
          `TMR_OFS_CNT_H, `TMR_OFS_CMPA_H, `TMR_OFS_CMPB_H,
          `TMR_OFS_CAP_H:
            temp_high <= pwdata[7:0];
          `TMR_OFS_CNT_L: begin
            counter_register <= {temp_high, pwdata[7:0]};
            block_match      <= 1'b1;
          end
          `TMR_OFS_CMPA_L:
            compare_a_register <= {temp_high, pwdata[7:0]};
          `TMR_OFS_CMPB_L:
            compare_b_register <= {temp_high, pwdata[7:0]};
          `TMR_OFS_CAP_L:
            capture_register <= {temp_high, pwdata[7:0]};
          `TMR_OFS_IRQ_MASK:
            timer_irq_mask <= pwdata[7:0] & `TMR_I_MASK;
          default: ;
        endcase
      end else if (rd_en && penable) begin
        // latch at the edge the low byte is taken, so a running
        // counter cannot split the pair
        case (paddr)
          `TMR_OFS_CNT_L:  temp_high <= counter_register[15:8];
          `TMR_OFS_CAP_L:  temp_high <= capture_register[15:8];
          default: ;
        endcase
      end
    end
  end

  // ========================================================================
  // read data; unmapped addresses and force bits read zero
  always @* begin
    rdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        `TMR_OFS_CTRL_A:    rdata[7:0] = timer_ctrl_a;
        `TMR_OFS_CTRL_B:    rdata[7:0] = timer_ctrl_b;
        `TMR_OFS_CTRL_C:    rdata[7:0] = 8'h00;
        `TMR_OFS_CNT_L:     rdata[7:0] = counter_register[7:0];
        `TMR_OFS_CMPA_L:    rdata[7:0] = compare_a_register[7:0];
        `TMR_OFS_CMPB_L:    rdata[7:0] = compare_b_register[7:0];
        `TMR_OFS_CAP_L:     rdata[7:0] = capture_register[7:0];
        `TMR_OFS_CNT_H, `TMR_OFS_CAP_H:
                            rdata[7:0] = temp_high;
        `TMR_OFS_CMPA_H:    rdata[7:0] = compare_a_register[15:8];
        `TMR_OFS_CMPB_H:    rdata[7:0] = compare_b_register[15:8];
        `TMR_OFS_IRQ_MASK:  rdata[7:0] = timer_irq_mask & `TMR_I_MASK;
        `TMR_OFS_IRQ_FLAGS: rdata[7:0] = timer_irq_flags & `TMR_I_MASK;
        default:            rdata = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // interrupt requests
  assign irq_capture   = global_irq_en & timer_irq_mask[`TMR_I_CAP] &
                         timer_irq_flags[`TMR_I_CAP];
  assign irq_compare_a = global_irq_en & timer_irq_mask[`TMR_I_CMPA] &
                         timer_irq_flags[`TMR_I_CMPA];
  assign irq_compare_b = global_irq_en & timer_irq_mask[`TMR_I_CMPB] &
                         timer_irq_flags[`TMR_I_CMPB];
  assign irq_overflow  = global_irq_en & timer_irq_mask[`TMR_I_OVF] &
                         timer_irq_flags[`TMR_I_OVF];
endmodule // tmr_timer16

// ==== verification/tmr_timer16_sva.sv ====
// checker for the timer register block, bound to tmr_timer16
// assumes zero-wait apb and shadows the control writes it sees
`timescale 1ns/100ps
`include "tmr_defines.vh"
module tmr_timer16_sva #(
  parameter PRESC_W = 10
) (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        global_irq_en,
  input logic        compare_a_output,
  input logic        compare_b_output,
  input logic        irq_capture,
  input logic        irq_compare_a,
  input logic        irq_compare_b,
  input logic        irq_overflow
);
  // ==========================================================================
  // shadows of the control bytes
  logic [7:0] ca;
  logic [7:0] cb;
  wire wr = psel && penable && pwrite && pready;
  wire rd = psel && penable && !pwrite;
  wire stop = cb[2:0] == 3'h0;
  wire npwm = ca[1:0] == 2'h0 && cb[4:3] != 2'h2;
  wire frc = wr && paddr == `TMR_OFS_CTRL_C;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ca <= 8'h00;
      cb <= 8'h00;
    end else if (wr && paddr == `TMR_OFS_CTRL_A) begin
      ca <= pwdata[7:0];
    end else if (wr && paddr == `TMR_OFS_CTRL_B) begin
      cb <= pwdata[7:0];
    end
  end
  // ==========================================================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence force_a_s;
    frc && pwdata[7] && npwm;
  endsequence
  sequence force_b_s;
    frc && pwdata[6] && npwm;
  endsequence
  irq_gate_a: assert property (
    irq_capture || irq_compare_a || irq_compare_b || irq_overflow
    |-> global_irq_en) else $error("irq without global enable");
  rsvd_irq_a: assert property (
    rd && (paddr == `TMR_OFS_IRQ_MASK || paddr == `TMR_OFS_IRQ_FLAGS)
    |-> prdata[7:6] == 2'h0 && prdata[4:3] == 2'h0)
    else $error("reserved irq bits not zero");
  force_read_a: assert property (
    rd && paddr == `TMR_OFS_CTRL_C |-> prdata == 32'h0)
    else $error("force register read not zero");
  ctrlb_read_a: assert property (
    rd && paddr == `TMR_OFS_CTRL_B |-> prdata[7:0] == (cb & 8'hDF))
    else $error("ctrl b readback wrong");
  reset_quiet_a: assert property (
    $rose(presetn) |-> !(compare_a_output || compare_b_output
    || irq_capture || irq_compare_a || irq_compare_b || irq_overflow))
    else $error("outputs active after reset");
  force_set_a: assert property (
    force_a_s ##0 ca[7:6] == 2'h3 |-> ##[1:2] compare_a_output)
    else $error("forced set of output a missing");
  force_clear_a: assert property (
    force_b_s ##0 ca[5:4] == 2'h2 |-> ##[1:2] !compare_b_output)
    else $error("forced clear of output b missing");
  pwm_force_a: assert property (
    frc && pwdata[7] && !npwm && stop |=> $stable(compare_a_output) [*3])
    else $error("force acted in pwm mode");
  force_noflag_a: assert property (
    frc && pwdata[7] && stop && !irq_compare_a |=> !irq_compare_a [*3])
    else $error("force raised compare irq");
endmodule // tmr_timer16_sva
bind tmr_timer16 tmr_timer16_sva #(.PRESC_W(PRESC_W)) tmr_timer16_sva_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .global_irq_en(global_irq_en),
  .compare_a_output(compare_a_output), .compare_b_output(compare_b_output),
  .irq_capture(irq_capture), .irq_compare_a(irq_compare_a),
  .irq_compare_b(irq_compare_b), .irq_overflow(irq_overflow));

// ==== verification/tmr_timer16_bench.sv ====
// self-checking bench for tmr_timer16: apb master and pin stimulus
// assumes zero-wait apb slave and the offsets of tmr_defines.vh
`timescale 1ns/100ps
`include "tmr_defines.vh"
module tmr_timer16_bench;
  // ==========================================================================
  // signals
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready, pslverr, cap_pin, cmp_out, cap_src, ext_pin, gie;
  logic [3:0]  ack;
  logic        oa, ob, iq_c, iq_a, iq_b, iq_o;
  int          failures, comparisons;
  logic [7:0]  rv;
  logic [15:0] v, w;
  logic        e, f;
  logic [11:0] base [3] = '{`TMR_OFS_CNT_L, `TMR_OFS_CMPA_L, `TMR_OFS_CMPB_L};
  tmr_timer16 #(.PRESC_W(10)) tmr_timer16_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_pin(cap_pin),
    .comparator_out(cmp_out), .capture_src_comparator(cap_src),
    .ext_clock_pin(ext_pin), .global_irq_en(gie),
    .vector_ack_capture(ack[0]), .vector_ack_compare_a(ack[1]),
    .vector_ack_compare_b(ack[2]), .vector_ack_overflow(ack[3]),
    .compare_a_output(oa), .compare_b_output(ob), .irq_capture(iq_c),
    .irq_compare_a(iq_a), .irq_compare_b(iq_b), .irq_overflow(iq_o));
  always #2.5 pclk = ~pclk;
  // ==========================================================================
  // tasks
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wn, input logic [11:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    psel <= 1'b1; pwrite <= wn; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [7:0] x);
    logic [7:0] q;
    apb(1'b0, a, 8'h00, q);
    check(nm, q, x);
  endtask
  task automatic wr16(input logic [11:0] a, input logic [15:0] d);
    wr(a + 12'h004, d[15:8]);
    wr(a, d[7:0]);
  endtask
  // low byte first, it latches the shared high byte
  task automatic get16(input logic [11:0] a, output logic [15:0] d);
    apb(1'b0, a, 8'h00, d[7:0]);
    apb(1'b0, a + 12'h004, 8'h00, d[15:8]);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic set_in(input logic b);
    cap_pin <= b; cmp_out <= b;
  endtask
  // slack of a few cycles: the prescaler runs free
  function automatic logic in_span(input int s, input logic [15:0] c);
    int sh;
    sh = s == 2 ? 3 : s == 3 ? 6 : s == 4 ? 8 : s == 5 ? 10 : 0;
    if (s == 0) return c == 16'h0000;
    if (s > 5) return c == 16'h000A;
    return c >= (2048 >> sh) - 1 && c <= (2056 >> sh) + 1;
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    tally_and_finish;
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    cap_pin = 0; cmp_out = 0; cap_src = 0; ext_pin = 0; gie = 0; ack = 0;
    failures = 0; comparisons = 0;
    rv = 8'($urandom(32'h0543ae77));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 'h40; a += 4) rd_chk("reset", 12'(a), 8'h00);
    rv = 8'($urandom);
    wr(`TMR_OFS_IRQ_MASK, rv);
    rd_chk("mask", `TMR_OFS_IRQ_MASK, rv & 8'h27);
    wr(`TMR_OFS_CTRL_A, rv);
    rd_chk("ctrl_a", `TMR_OFS_CTRL_A, rv & 8'hF3);
    wr(`TMR_OFS_CTRL_A, 8'h00);
    wr(`TMR_OFS_CTRL_B, rv & 8'hDF);
    rd_chk("ctrl_b", `TMR_OFS_CTRL_B, rv & 8'hDF);
    wr(`TMR_OFS_CTRL_B, 8'h00);
    foreach (base[i]) repeat (3) begin
      v = 16'($urandom);
      wr16(base[i], v);
      get16(base[i], w);
      check("word", w, v);
    end
    // compare b equals the written count: the first tick must not match
    wr(`TMR_OFS_IRQ_MASK, 8'h27);
    // the random control byte above may have run the timer: drop its flags
    wr(`TMR_OFS_IRQ_FLAGS, 8'h27);
    gie <= 1'b1;
    wr16(`TMR_OFS_CMPA_L, 16'hFFF8);
    wr16(`TMR_OFS_CMPB_L, 16'hFFF0);
    wr16(`TMR_OFS_CNT_L, 16'hFFF0);
    wr(`TMR_OFS_CTRL_B, 8'h01);
    cyc(30);
    wr(`TMR_OFS_CTRL_B, 8'h00);
    rd_chk("flags", `TMR_OFS_IRQ_FLAGS, 8'h03);
    check("irq_a", {iq_c, iq_a, iq_b, iq_o}, 4'b0101);
    gie <= 1'b0;
    cyc(1);
    check("irq_off", {iq_a, iq_o}, 2'b00);
    wr(`TMR_OFS_IRQ_FLAGS, 8'h01);
    rd_chk("w1c", `TMR_OFS_IRQ_FLAGS, 8'h02);
    ack <= 4'hE;
    cyc(1);
    ack <= 4'h0;
    rd_chk("vector", `TMR_OFS_IRQ_FLAGS, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr16(`TMR_OFS_CNT_L, 16'h0000);
      wr(`TMR_OFS_CTRL_B, 8'(s));
      if (s < 6) cyc(2048);
      else repeat (20) begin
        ext_pin <= ~ext_pin;
        cyc(4);
      end
      wr(`TMR_OFS_CTRL_B, 8'h00);
      get16(`TMR_OFS_CNT_L, w);
      check("span", in_span(s, w), 1'b1);
    end
    gie <= 1'b1;
    wr(`TMR_OFS_CTRL_A, 8'hE0);
    wr(`TMR_OFS_CTRL_C, 8'hC0);
    cyc(2);
    check("force1", {oa, ob}, 2'b10);
    wr(`TMR_OFS_CTRL_A, 8'hB0);
    wr(`TMR_OFS_CTRL_C, 8'hC0);
    cyc(2);
    check("force2", {oa, ob}, 2'b01);
    rd_chk("force_rd", `TMR_OFS_CTRL_C, 8'h00);
    rd_chk("force_flag", `TMR_OFS_IRQ_FLAGS, 8'h00);
    // a strobe written in a pwm mode on purpose, to see it ignored
    wr(`TMR_OFS_CTRL_A, 8'h51);
    wr(`TMR_OFS_CTRL_C, 8'hC0);
    cyc(2);
    check("pwm_force", {oa, ob}, 2'b01);
    wr(`TMR_OFS_CTRL_A, 8'h00);
    for (int i = 0; i < 4; i++) begin
      e = i[0];
      f = i[1];
      cap_src <= (i == 3);
      set_in(~e);
      cyc(12);
      v = 16'($urandom);
      wr16(`TMR_OFS_CNT_L, v);
      wr(`TMR_OFS_CTRL_B, {f, e, 6'h00});
      wr(`TMR_OFS_IRQ_FLAGS, 8'h20);
      if (f) begin
        set_in(e);
        cyc(2);
        set_in(~e);
        cyc(12);
        rd_chk("glitch", `TMR_OFS_IRQ_FLAGS, 8'h00);
      end
      set_in(e);
      cyc(12);
      rd_chk("cap_flag", `TMR_OFS_IRQ_FLAGS, 8'h20);
      get16(`TMR_OFS_CAP_L, w);
      check("cap", w, v);
      check("irq_c", iq_c, 1'b1);
      if (i[0]) begin
        ack <= 4'h1;
        cyc(1);
        ack <= 4'h0;
      end else begin
        wr(`TMR_OFS_IRQ_FLAGS, 8'h20);
      end
      set_in(~e);
      cyc(12);
      rd_chk("wrong_edge", `TMR_OFS_IRQ_FLAGS, 8'h00);
    end
    wr(`TMR_OFS_CTRL_B, 8'h58);
    wr(`TMR_OFS_IRQ_FLAGS, 8'h20);
    set_in(1'b1);
    cyc(12);
    rd_chk("cap_top", `TMR_OFS_IRQ_FLAGS, 8'h00);
    tally_and_finish;
  end
endmodule // tmr_timer16_bench
